// *** design/fcr_pkg.sv ***
package fcr_pkg;
    // ==========================================================
    // error codes
    localparam logic [15:0] FCR_ERR_INT_GENERAL = 16'h0001;
    localparam logic [15:0] FCR_ERR_INT_TIMING = 16'h0002;
    localparam logic [15:0] FCR_ERR_INT_APPHANG = 16'h0003;
    localparam logic [15:0] FCR_ERR_COM_GENERAL = 16'h1001;
    localparam logic [15:0] FCR_ERR_COM_BADREG = 16'h1002;
    localparam logic [15:0] FCR_ERR_MB_PARITY = 16'h1101;
    localparam logic [15:0] FCR_ERR_MB_FRAMING = 16'h1102;
    localparam logic [15:0] FCR_ERR_MB_OVERRUN = 16'h1103;
    localparam logic [15:0] FCR_ERR_MB_CHECKSUM = 16'h1104;
    localparam logic [15:0] FCR_ERR_MB_ILLFUNC = 16'h1105;
    localparam logic [15:0] FCR_ERR_MB_ILLDIAG = 16'h1106;
    localparam logic [15:0] FCR_ERR_OVERCURRENT = 16'h2001;
    localparam logic [15:0] FCR_ERR_UNDERVOLT = 16'h3001;
    localparam logic [15:0] FCR_ERR_OVERVOLT = 16'h3002;
    localparam logic [15:0] FCR_ERR_TEMP_ELEC = 16'h4001;
    localparam logic [15:0] FCR_ERR_TEMP_WIND = 16'h4002;
    localparam logic [15:0] FCR_ERR_TORQUE = 16'h5001;
    localparam logic [15:0] FCR_ERR_LOCKED = 16'h6001;
    localparam logic [15:0] FCR_ERR_REGULATOR = 16'h7001;
    localparam logic [15:0] FCR_ERR_NONE = 16'h0000;

    // ==========================================================
    // event sources, index into the event vector (priority: low wins)
    localparam int FCR_NEV = 19;
    localparam int FCR_EV_OVERCURRENT = 0;
    localparam int FCR_EV_OVERVOLT = 1;
    localparam int FCR_EV_UNDERVOLT = 2;
    localparam int FCR_EV_TEMP_ELEC = 3;
    localparam int FCR_EV_TEMP_WIND = 4;
    localparam int FCR_EV_INT_GENERAL = 5;
    localparam int FCR_EV_INT_TIMING = 6;
    localparam int FCR_EV_INT_APPHANG = 7;
    localparam int FCR_EV_LOCKED = 8;
    localparam int FCR_EV_REGULATOR = 9;
    localparam int FCR_EV_TORQUE = 10;
    localparam int FCR_EV_COM_GENERAL = 11;
    localparam int FCR_EV_COM_BADREG = 12;
    localparam int FCR_EV_MB_PARITY = 13;
    localparam int FCR_EV_MB_FRAMING = 14;
    localparam int FCR_EV_MB_OVERRUN = 15;
    localparam int FCR_EV_MB_CHECKSUM = 16;
    localparam int FCR_EV_MB_ILLFUNC = 17;
    localparam int FCR_EV_MB_ILLDIAG = 18;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] FCR_OFF_ERROR = 8'h00;
    localparam logic [7:0] FCR_OFF_SUPPLY = 8'h04;
    localparam logic [7:0] FCR_OFF_OV_LIMIT = 8'h08;
    localparam logic [7:0] FCR_OFF_UV_LIMIT = 8'h0C;
    localparam logic [7:0] FCR_OFF_STATUS = 8'h10;
    localparam logic [7:0] FCR_OFF_CONTROL = 8'h14;
    localparam logic [7:0] FCR_OFF_IRQ_STATUS = 8'h18;
    localparam logic [7:0] FCR_OFF_IRQ_ENABLE = 8'h1C;
    localparam logic [7:0] FCR_OFF_IRQ_CLEAR = 8'h20;

    // status register fields
    localparam int FCR_ST_HIGHV = 0;
    localparam int FCR_ST_LOWV = 1;
    localparam int FCR_ST_DRV_OFF = 2;
    localparam int FCR_ST_FACTORY = 3;
    localparam int FCR_ST_FIRMWARE = 4;
    localparam int FCR_ST_STRAPPED = 5;
    // control register fields
    localparam int FCR_CT_DRV_EN = 0;
    localparam int FCR_CT_OV_REARM = 1;
    // interrupt status fields
    localparam int FCR_IRQ_ERROR = 0;
    localparam int FCR_IRQ_OVTRIP = 1;
    localparam int FCR_NIRQ = 2;

    // reset values
    localparam logic [15:0] FCR_RST_OV_LIMIT = 16'hFFFF;
    localparam logic [15:0] FCR_RST_UV_LIMIT = 16'h0000;
    localparam logic [1:0] FCR_RST_CONTROL = 2'h0;
    localparam logic [1:0] FCR_RST_IRQ_ENABLE = 2'h0;

    // ==========================================================
    // strap sampling timing
    localparam int FCR_STRAP_SETTLE_US = 10;
    localparam int FCR_CLK_MHZ = 100;
    localparam int FCR_STRAP_SETTLE_CYC = FCR_STRAP_SETTLE_US * FCR_CLK_MHZ;

    typedef enum logic [1:0] {
        FCR_STRAP_WAIT,
        FCR_STRAP_SAMPLE,
        FCR_STRAP_DONE
    } fcr_strap_type;
endpackage

// *** design/fcr_fault_code_reporting.sv ***
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module fcr_fault_code_reporting
    import fcr_pkg::*;
#(
    parameter int VOLT_W = 16,
    parameter int STRAP_SETTLE = fcr_pkg::FCR_STRAP_SETTLE_CYC
) (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async power-on reset
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write strobe
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic [fcr_pkg::FCR_NEV-1:0] fault_event, // one bit per fault source
    input wire logic [VOLT_W-1:0] supply_level, // measured supply voltage
    input wire logic strap_common_input, // strap driver pin level
    input wire logic firmware_strap_input, // firmware strap pin
    input wire logic factory_reset_strap_input, // factory strap pin
    output logic motor_drive_enable, // gates the power stage
    output logic high_voltage_flag, // supply above limit
    output logic factory_restore, // restore defaults request
    output logic firmware_mode, // start in firmware mode
    output logic irq // level interrupt
);
    import fcr_pkg::*;

    // ==========================================================
    // code table
    function automatic logic [15:0] fcr_code(input int idx);
        logic [15:0] c;
        c = FCR_ERR_NONE;
        unique case (idx)
            FCR_EV_INT_GENERAL: c = FCR_ERR_INT_GENERAL;
            FCR_EV_INT_TIMING: c = FCR_ERR_INT_TIMING;
            FCR_EV_INT_APPHANG: c = FCR_ERR_INT_APPHANG;
            FCR_EV_COM_GENERAL: c = FCR_ERR_COM_GENERAL;
            FCR_EV_COM_BADREG: c = FCR_ERR_COM_BADREG;
            FCR_EV_MB_PARITY: c = FCR_ERR_MB_PARITY;
            FCR_EV_MB_FRAMING: c = FCR_ERR_MB_FRAMING;
            FCR_EV_MB_OVERRUN: c = FCR_ERR_MB_OVERRUN;
            FCR_EV_MB_CHECKSUM: c = FCR_ERR_MB_CHECKSUM;
            FCR_EV_MB_ILLFUNC: c = FCR_ERR_MB_ILLFUNC;
            FCR_EV_MB_ILLDIAG: c = FCR_ERR_MB_ILLDIAG;
            FCR_EV_OVERCURRENT: c = FCR_ERR_OVERCURRENT;
            FCR_EV_UNDERVOLT: c = FCR_ERR_UNDERVOLT;
            FCR_EV_OVERVOLT: c = FCR_ERR_OVERVOLT;
            FCR_EV_TEMP_ELEC: c = FCR_ERR_TEMP_ELEC;
            FCR_EV_TEMP_WIND: c = FCR_ERR_TEMP_WIND;
            FCR_EV_TORQUE: c = FCR_ERR_TORQUE;
            FCR_EV_LOCKED: c = FCR_ERR_LOCKED;
            FCR_EV_REGULATOR: c = FCR_ERR_REGULATOR;
            default: c = FCR_ERR_NONE;
        endcase
        return c;
    endfunction

    // ==========================================================
    // registers
    logic [15:0] error_code;
    logic [VOLT_W-1:0] supply;
    logic [VOLT_W-1:0] ov_limit;
    logic [VOLT_W-1:0] uv_limit;
    logic [1:0] control;
    logic [FCR_NIRQ-1:0] irq_status;
    logic [FCR_NIRQ-1:0] irq_enable;
    logic drive_tripped;
    logic over_q;
    logic under_q;
    fcr_strap_type strap_state;
    logic [31:0] strap_count;
    logic strapped;

    // ==========================================================
    // ahb address phase capture
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    wire addr_phase = hsel & hready & htrans[1];
    wire size_ok = (hsize == 3'b010);

    // data phase is always zero wait; unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else if (hready) begin
            dp_valid <= addr_phase & size_ok;
            dp_write <= hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    wire wr = dp_valid & dp_write;
    wire wr_ov = wr & (dp_addr == FCR_OFF_OV_LIMIT);
    wire wr_uv = wr & (dp_addr == FCR_OFF_UV_LIMIT);
    wire wr_ctl = wr & (dp_addr == FCR_OFF_CONTROL);
    wire wr_ien = wr & (dp_addr == FCR_OFF_IRQ_ENABLE);
    wire wr_icl = wr & (dp_addr == FCR_OFF_IRQ_CLEAR);

    // ==========================================================
    // fault priority encoding: lowest index wins on a tie
    logic [15:0] next_error_code;
    logic any_event;
    always_comb begin
        next_error_code = error_code;
        any_event = 1'b0;
        for (int i = FCR_NEV - 1; i >= 0; i--) begin
            if (fault_event[i]) begin
                next_error_code = fcr_code(i);
                any_event = 1'b1;
            end
        end
    end

    // supply comparison against software limits
    wire over_volt = (supply > ov_limit);
    wire under_volt = (supply < uv_limit);
    wire over_rise = over_volt & ~over_q;
    wire under_rise = under_volt & ~under_q;

    // error code only moves when a new fault arrives; never cleared by reading
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            error_code <= FCR_ERR_NONE;
        end else if (any_event) begin
            error_code <= next_error_code;
        end else if (over_rise) begin
            error_code <= FCR_ERR_OVERVOLT;
        end else if (under_rise) begin
            error_code <= FCR_ERR_UNDERVOLT;
        end
    end

    // supply sample follows the input every cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            supply <= '0;
            over_q <= 1'b0;
            under_q <= 1'b0;
        end else begin
            supply <= supply_level;
            over_q <= over_volt;
            under_q <= under_volt;
        end
    end

    // ==========================================================
    // overvoltage shutdown: latched until software rearms while safe
    wire ov_event = over_volt | fault_event[FCR_EV_OVERVOLT];
    wire rearm = wr_ctl & hwdata[FCR_CT_OV_REARM];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_tripped <= 1'b0;
        end else if (ov_event) begin
            drive_tripped <= 1'b1;
        end else if (rearm) begin
            drive_tripped <= 1'b0;
        end
    end

    // configuration writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ov_limit <= VOLT_W'(FCR_RST_OV_LIMIT);
            uv_limit <= VOLT_W'(FCR_RST_UV_LIMIT);
            control <= FCR_RST_CONTROL;
            irq_enable <= FCR_RST_IRQ_ENABLE;
        end else begin
            if (wr_ov) ov_limit <= hwdata[VOLT_W-1:0];
            if (wr_uv) uv_limit <= hwdata[VOLT_W-1:0];
            if (wr_ctl) control <= {1'b0, hwdata[FCR_CT_DRV_EN]};
            if (wr_ien) irq_enable <= hwdata[FCR_NIRQ-1:0];
        end
    end

    // drive is off while tripped, even with software enable set
    assign motor_drive_enable = control[FCR_CT_DRV_EN] & ~drive_tripped;
    assign high_voltage_flag = over_q;

    // ==========================================================
    // interrupts: set beats clear in the same cycle
    logic [FCR_NIRQ-1:0] irq_set;
    assign irq_set[FCR_IRQ_ERROR] = any_event | over_rise | under_rise;
    assign irq_set[FCR_IRQ_OVTRIP] = ov_event & ~drive_tripped;
    wire [FCR_NIRQ-1:0] irq_clr = wr_icl ? hwdata[FCR_NIRQ-1:0] : '0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
        end
    end
    assign irq = |(irq_status & irq_enable);

    // ==========================================================
    // strap sampler: waits for pins to settle after reset, samples once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_state <= FCR_STRAP_WAIT;
            strap_count <= '0;
        end else begin
            unique case (strap_state)
                FCR_STRAP_WAIT: begin
                    if (strap_count >= 32'(STRAP_SETTLE - 1)) begin
                        strap_state <= FCR_STRAP_SAMPLE;
                    end
                    strap_count <= strap_count + 32'd1;
                end
                FCR_STRAP_SAMPLE: strap_state <= FCR_STRAP_DONE;
                FCR_STRAP_DONE: strap_state <= FCR_STRAP_DONE;
                default: strap_state <= FCR_STRAP_WAIT;
            endcase
        end
    end

    // the common pin drives the outside pair; a tie shows as equal,
    // asserted levels on both pins at the sample instant
    wire tie_factory = strap_common_input & factory_reset_strap_input;
    wire tie_firmware = strap_common_input & firmware_strap_input;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            factory_restore <= 1'b0;
            firmware_mode <= 1'b0;
            strapped <= 1'b0;
        end else if (strap_state == FCR_STRAP_SAMPLE) begin
            factory_restore <= tie_factory;
            firmware_mode <= tie_firmware;
            strapped <= 1'b1;
        end
    end

    // ==========================================================
    // read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (dp_addr)
            FCR_OFF_ERROR: rd_mux = {16'h0000, error_code};
            FCR_OFF_SUPPLY: rd_mux = 32'(supply);
            FCR_OFF_OV_LIMIT: rd_mux = 32'(ov_limit);
            FCR_OFF_UV_LIMIT: rd_mux = 32'(uv_limit);
            FCR_OFF_STATUS: rd_mux = 32'({strapped, firmware_mode, factory_restore,
                drive_tripped, under_q, over_q});
            FCR_OFF_CONTROL: rd_mux = 32'(control);
            FCR_OFF_IRQ_STATUS: rd_mux = 32'(irq_status);
            FCR_OFF_IRQ_ENABLE: rd_mux = 32'(irq_enable);
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    assign hrdata = (dp_valid & ~dp_write) ? rd_mux : 32'h0000_0000;
endmodule // fcr_fault_code_reporting

// *** tb/fcr_fault_code_reporting_sva.sv ***
`timescale 1ns/1ps
// ==========================================================
// port-level checks of the fault reporting block
module fcr_fault_code_reporting_sva
    import fcr_pkg::*;
#(
    parameter int STRAP_SETTLE = 4
) (
    input wire logic hclk, // clock
    input wire logic hresetn, // reset, active low
    input wire logic hsel, // select
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic hready, // bus ready
    input wire logic [31:0] hrdata, // read data
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic [fcr_pkg::FCR_NEV-1:0] fault_event, // fault sources
    input wire logic strap_common_input, // strap driver
    input wire logic firmware_strap_input, // firmware strap
    input wire logic factory_reset_strap_input, // factory strap
    input wire logic motor_drive_enable, // power stage gate
    input wire logic high_voltage_flag, // high supply
    input wire logic factory_restore, // restore request
    input wire logic firmware_mode, // firmware start
    input wire logic irq // interrupt
);
    import fcr_pkg::*;
    logic rd_phase;
    logic wr_phase;
    int cnt;
    wire logic take = hsel & hready & htrans[1];
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // data phase trackers, cycles since release capped to avoid wrap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_phase <= 1'b0;
            wr_phase <= 1'b0;
            cnt <= 0;
        end else begin
            rd_phase <= take & ~hwrite;
            wr_phase <= take & hwrite;
            cnt <= (cnt < 100000) ? cnt + 1 : cnt;
        end
    end
    // ==========================================================
    // drive trip: off from the next cycle and held off for three cycles
    sequence s_off_hold;
        (!motor_drive_enable) [*3];
    endsequence
    a_bus_always_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_rdata_idle_zero: assert property (!rd_phase |-> hrdata == 32'h0000_0000)
        else $error("read data outside data phase");
    a_ov_trip_drive: assert property (fault_event[FCR_EV_OVERVOLT] |-> ##1 s_off_hold)
        else $error("drive not off after overvoltage");
    a_hv_drive_off: assert property ($rose(high_voltage_flag) |-> ##[0:2] !motor_drive_enable)
        else $error("drive on during high voltage");
    a_drive_needs_write: assert property ($rose(motor_drive_enable) |-> $past(wr_phase))
        else $error("drive enabled without a write");
    a_irq_sticky_hold: assert property ($fell(irq) |-> $past(wr_phase))
        else $error("interrupt dropped without a write");
    a_strap_sample_value: assert property ((cnt == STRAP_SETTLE + 4) |->
        (firmware_mode == (strap_common_input & firmware_strap_input)) &&
        (factory_restore == (strap_common_input & factory_reset_strap_input)))
        else $error("strap result wrong");
    a_strap_once_only: assert property ((cnt > STRAP_SETTLE + 4) |->
        $stable(firmware_mode) && $stable(factory_restore))
        else $error("strap result changed after power-up");
endmodule // fcr_fault_code_reporting_sva

bind fcr_fault_code_reporting fcr_fault_code_reporting_sva #(.STRAP_SETTLE(STRAP_SETTLE)) u_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .fault_event(fault_event), .strap_common_input(strap_common_input),
    .firmware_strap_input(firmware_strap_input),
    .factory_reset_strap_input(factory_reset_strap_input),
    .motor_drive_enable(motor_drive_enable), .high_voltage_flag(high_voltage_flag),
    .factory_restore(factory_restore), .firmware_mode(firmware_mode), .irq(irq));

// *** tb/fcr_host_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// host side bus master, single word transfers only
module fcr_host_model (
    input wire logic hclk, // clock
    output logic hsel, // select
    output logic [31:0] haddr, // byte address
    output logic [1:0] htrans, // transfer type
    output logic hwrite, // write
    output logic [2:0] hsize, // size
    output logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    input wire logic [31:0] hrdata, // read data
    output logic timed_out // wait ran out
);
    // idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        timed_out = 1'b0;
    end
    // address phase held until ready, then data phase; bounded waits
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        int n;
        n = 0;
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        hsel <= 1'b0;
        haddr <= ~a;
        htrans <= 2'b00;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        r = hrdata;
        // released data must not keep showing the old word
        hwdata <= ~d;
        // blocking, so the caller sees the flag as soon as the task returns
        if (n >= 50) timed_out = 1'b1;
    endtask
endmodule // fcr_host_model

// *** tb/tb.sv ***
`timescale 1ns/1ps
// ==========================================================
// testbench of the fault reporting block
module tb;
    import fcr_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [FCR_NEV-1:0] fault_event = '0;
    logic [15:0] supply_level = 16'h0100;
    logic strap_c = 1'b0;
    logic strap_fw = 1'b0;
    logic strap_fac = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, drv, hv, fac, fw, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int mismatches = 0;
    int tests_run = 0;
    logic [15:0] codes [FCR_NEV] = '{16'h2001, 16'h3002, 16'h3001, 16'h4001, 16'h4002,
        16'h0001, 16'h0002, 16'h0003, 16'h6001, 16'h7001, 16'h5001, 16'h1001, 16'h1002,
        16'h1101, 16'h1102, 16'h1103, 16'h1104, 16'h1105, 16'h1106};
    // clock, 10 ns period
    always #5 hclk = ~hclk;
    // short settle count keeps the strap wait brief
    fcr_fault_code_reporting #(.VOLT_W(16), .STRAP_SETTLE(4)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fault_event(fault_event),
        .supply_level(supply_level), .strap_common_input(strap_c),
        .firmware_strap_input(strap_fw), .factory_reset_strap_input(strap_fac),
        .motor_drive_enable(drv), .high_voltage_flag(hv), .factory_restore(fac),
        .firmware_mode(fw), .irq(irq));
    fcr_host_model u_host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .timed_out());
    // ==========================================================
    // verdict, compare and bus helpers
    task finish_test;
        if (mismatches == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task xf(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        u_host.xfer(w, {24'h00_0000, a}, d, r);
        if (u_host.timed_out === 1'b1) begin
            mismatches++;
            finish_test;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xf(1'b1, a, d, r);
        // the write lands on the last edge; let outputs settle before any compare
        @(posedge hclk);
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xf(1'b0, a, 32'h0000_0000, r);
        chk(r, exp);
    endtask
    task pulse(input logic [FCR_NEV-1:0] m);
        @(posedge hclk);
        fault_event <= m;
        @(posedge hclk);
        fault_event <= '0;
    endtask
    task power_up(input logic tie_fw, input logic tie_fac);
        hresetn <= 1'b0;
        strap_c <= 1'b1;
        strap_fw <= tie_fw;
        strap_fac <= tie_fac;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (10) @(posedge hclk);
    endtask
    // ==========================================================
    // scenarios
    task t_straps;
        chk({fac, fw}, 32'h0000_0001);
        rd_chk(FCR_OFF_STATUS, 32'h0000_0030);
        strap_fw <= 1'b0;
        strap_fac <= 1'b1;
        repeat (10) @(posedge hclk);
        chk({fac, fw}, 32'h0000_0001);
        power_up(1'b0, 1'b1);
        chk({fac, fw}, 32'h0000_0002);
        rd_chk(FCR_OFF_STATUS, 32'h0000_0028);
    endtask
    task t_regs;
        rd_chk(FCR_OFF_OV_LIMIT, 32'h0000_FFFF);
        rd_chk(FCR_OFF_UV_LIMIT, 32'h0000_0000);
        rd_chk(FCR_OFF_CONTROL, 32'h0000_0000);
        rd_chk(FCR_OFF_IRQ_ENABLE, 32'h0000_0000);
        wr(FCR_OFF_ERROR, 32'hFFFF_1234);
        rd_chk(FCR_OFF_ERROR, 32'h0000_0000);
        wr(8'h40, 32'h0000_5555);
        rd_chk(8'h40, 32'h0000_0000);
    endtask
    task t_codes;
        wr(FCR_OFF_IRQ_ENABLE, 32'h0000_0001);
        for (int i = 0; i < FCR_NEV; i++) begin
            pulse(19'h0_0001 << i);
            rd_chk(FCR_OFF_ERROR, {16'h0000, codes[i]});
            chk({31'h0, irq}, 32'h0000_0001);
            wr(FCR_OFF_IRQ_CLEAR, 32'h0000_0003);
            chk({31'h0, irq}, 32'h0000_0000);
        end
        wr(FCR_OFF_IRQ_ENABLE, 32'h0000_0000);
        pulse(19'h0_0200);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(FCR_OFF_IRQ_ENABLE, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0001);
    endtask
    task t_priority;
        pulse(19'h4_2001);
        rd_chk(FCR_OFF_ERROR, 32'h0000_2001);
        pulse(19'h4_2000);
        rd_chk(FCR_OFF_ERROR, 32'h0000_1101);
    endtask
    task t_voltage;
        supply_level <= 16'h0123;
        repeat (2) @(posedge hclk);
        rd_chk(FCR_OFF_SUPPLY, 32'h0000_0123);
        wr(FCR_OFF_OV_LIMIT, 32'h0000_0200);
        wr(FCR_OFF_CONTROL, 32'h0000_0003);
        rd_chk(FCR_OFF_CONTROL, 32'h0000_0001);
        chk({hv, drv}, 32'h0000_0001);
        supply_level <= 16'h0250;
        repeat (4) @(posedge hclk);
        chk({hv, drv}, 32'h0000_0002);
        rd_chk(FCR_OFF_ERROR, 32'h0000_3002);
        rd_chk(FCR_OFF_STATUS, 32'h0000_002D);
        rd_chk(FCR_OFF_IRQ_STATUS, 32'h0000_0003);
        supply_level <= 16'h0180;
        repeat (4) @(posedge hclk);
        chk({hv, drv}, 32'h0000_0000);
        wr(FCR_OFF_CONTROL, 32'h0000_0003);
        chk({hv, drv}, 32'h0000_0001);
        wr(FCR_OFF_UV_LIMIT, 32'h0000_0100);
        supply_level <= 16'h0050;
        repeat (4) @(posedge hclk);
        rd_chk(FCR_OFF_ERROR, 32'h0000_3001);
        // reported overvoltage event must cut a running drive
        pulse(19'h0_0002);
        @(posedge hclk);
        chk({hv, drv}, 32'h0000_0000);
        rd_chk(FCR_OFF_ERROR, 32'h0000_3002);
    endtask
    // main sequence, firmware tie at first power-up
    initial begin
        power_up(1'b1, 1'b0);
        t_straps;
        t_regs;
        t_codes;
        t_priority;
        t_voltage;
        finish_test;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        finish_test;
    end
endmodule // tb
